/* design/odr_orient.sv */
// odr_orient: orientation detection with its four registers.
// assumes the register port is driven by the serial interface logic on
// clk_in and the sample and mode inputs by the sensor core on clk_in.
`default_nettype none

module odr_orient
  import odr_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_BASE_CYCLES
)(
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  // register port
  input  wire logic [7:0]                reg_addr_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  input  wire logic [7:0]                reg_wdata_in,
  output logic      [7:0]                reg_rdata_out,
  // sensor core
  input  wire logic signed [ACCEL_W-1:0] ax_in,
  input  wire logic signed [ACCEL_W-1:0] ay_in,
  input  wire logic signed [ACCEL_W-1:0] az_in,
  input  wire odr_pkg::odr_sysmode_e     sys_mode_in,
  input  wire odr_pkg::odr_osmode_e      os_mode_in,
  input  wire logic [2:0]                odr_code_in,
  // interrupt
  input  wire logic                      orient_int_enable_in,
  output logic                           orient_interrupt_source_out
);

  import odr_pkg::*;

  // ******************************
  // state
  // ******************************
  typedef struct packed {
    logic        orient_detect_enable;
    logic        debounce_mode;
    logic [7:0]  debounce_count;
    logic [1:0]  portrait_landscape_code;
    logic        back_front_flag;
    logic        z_tilt_lockout_flag;
    logic        orient_change_flag;
    logic        first_pending;
    logic [7:0]  dbc;
    logic [15:0] base_cnt;
    logic [7:0]  step_cnt;
    odr_sysmode_e prev_mode;
    logic [7:0]  rdata;
  } odr_state_s;

  localparam odr_state_s RESET_STATE = '{
    orient_detect_enable:    CFG_RESET[CFG_EN_BIT],
    debounce_mode:           CFG_RESET[CFG_MODE_BIT],
    debounce_count:          COUNT_RESET,
    portrait_landscape_code: CODE_PORTRAIT_UP,
    back_front_flag:         1'b0,
    z_tilt_lockout_flag:     1'b0,
    orient_change_flag:      1'b0,
    first_pending:           1'b1,
    dbc:                     8'h00,
    base_cnt:                16'h0000,
    step_cnt:                8'h00,
    prev_mode:               ODR_STANDBY,
    rdata:                   8'h00
  };

  localparam logic [15:0] BASE_LAST = 16'(STEP_CYCLES - 1);

  odr_state_s s;
  odr_state_s next_s;

  logic [1:0] cand_code;
  logic       cand_bf;
  logic       cand_lo;
  logic       over;
  logic       active;
  logic       run;
  logic       mode_change;
  logic       base_tick;
  logic       step;
  logic       differ;
  logic       set_evt;
  logic       rd_status;
  logic [7:0] mult;

  // ******************************
  // helpers
  // ******************************
  // time step in units of the 1.25 ms base step
  function automatic logic [7:0] step_mult(input logic [2:0] odr,
                                           input odr_osmode_e os);
    logic [7:0] m;
    m = (odr < 3'h5) ? 8'(8'h01 << odr) : 8'h10;
    case (os)
      ODR_OS_HIGH_RESOLUTION_MODE: begin
        m = (odr == 3'h0) ? 8'h01 : 8'h02;
      end
      ODR_OS_LOW_POWER_LOW_NOISE_MODE: begin
        if (odr >= 3'h5) m = 8'h40;
      end
      ODR_OS_LOWPOWER: begin
        if (odr == 3'h5) m = 8'h40;
        else if (odr > 3'h5) m = 8'h80;
      end
      default: begin
        m = m;
      end
    endcase
    return m;
  endfunction

  function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                          input odr_state_s st);
    logic [7:0] d;
    d = 8'h00;
    if (addr == ADDR_STATUS) begin
      d[ST_FLAG_BIT] = st.orient_change_flag;
      d[ST_LO_BIT] = st.z_tilt_lockout_flag;
      d[ST_CODE_LSB +: 2] = st.portrait_landscape_code;
      d[ST_BF_BIT] = st.back_front_flag;
    end else if (addr == ADDR_CONFIG) begin
      d[CFG_MODE_BIT] = st.debounce_mode;
      d[CFG_EN_BIT] = st.orient_detect_enable;
    end else if (addr == ADDR_COUNT) begin
      d = st.debounce_count;
    end else if (addr == ADDR_ZCOMP) begin
      d = ZCOMP_VALUE;
    end
    return d;
  endfunction

  // ******************************
  // candidate orientation
  // ******************************
  odr_classify u_classify (
    .ax_in    (ax_in),
    .ay_in    (ay_in),
    .az_in    (az_in),
    .code_out (cand_code),
    .bf_out   (cand_bf),
    .lo_out   (cand_lo),
    .over_out (over)
  );

  // ******************************
  // next state
  // ******************************
  always_comb begin
    next_s = s;
    active = sys_mode_in != ODR_STANDBY;
    run = active && s.orient_detect_enable;
    mode_change = (s.prev_mode == ODR_WAKE && sys_mode_in == ODR_SLEEP)
      || (s.prev_mode == ODR_SLEEP && sys_mode_in == ODR_WAKE);
    mult = step_mult(odr_code_in, os_mode_in);
    base_tick = s.base_cnt == BASE_LAST;
    step = run && base_tick && (s.step_cnt >= mult - 8'h01);
    differ = {cand_code, cand_bf, cand_lo} != {s.portrait_landscape_code,
      s.back_front_flag, s.z_tilt_lockout_flag};
    rd_status = reg_rd_in && reg_addr_in == ADDR_STATUS;
    set_evt = 1'b0;
    next_s.prev_mode = sys_mode_in;

    // step timer only runs while detection is live
    if (!run || mode_change) begin
      next_s.base_cnt = 16'h0000;
      next_s.step_cnt = 8'h00;
    end else if (base_tick) begin
      next_s.base_cnt = 16'h0000;
      next_s.step_cnt = step ? 8'h00 : s.step_cnt + 8'h01;
    end else begin
      next_s.base_cnt = s.base_cnt + 16'h0001;
    end

    if (!active) begin
      next_s.first_pending = 1'b1;
    end

    // over 1.25g nothing moves; the debounce counter holds unless a wake/sleep change clears it
    if (mode_change) begin
      next_s.dbc = 8'h00;
    end else if (step && !over) begin
      if (s.first_pending || (differ && s.dbc >= s.debounce_count)) begin
        next_s.portrait_landscape_code = cand_code;
        next_s.back_front_flag = cand_bf;
        next_s.z_tilt_lockout_flag = cand_lo;
        next_s.first_pending = 1'b0;
        next_s.dbc = 8'h00;
        set_evt = s.first_pending || differ;
      end else if (differ) begin
        next_s.dbc = s.dbc + 8'h01;
      end else if (s.debounce_mode) begin
        next_s.dbc = 8'h00;
      end else if (s.dbc != 8'h00) begin
        next_s.dbc = s.dbc - 8'h01;
      end
    end

    // a detection in the read cycle is kept: set wins over clear
    if (rd_status) begin
      next_s.orient_change_flag = 1'b0;
    end
    if (set_evt) begin
      next_s.orient_change_flag = 1'b1;
    end

    if (reg_wr_in) begin
      if (reg_addr_in == ADDR_CONFIG) begin
        next_s.debounce_mode = reg_wdata_in[CFG_MODE_BIT];
        next_s.orient_detect_enable = reg_wdata_in[CFG_EN_BIT];
      end else if (reg_addr_in == ADDR_COUNT) begin
        next_s.debounce_count = reg_wdata_in;
      end
    end

    if (reg_rd_in) begin
      next_s.rdata = read_mux(reg_addr_in, s);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // ******************************
  // outputs
  // ******************************
  assign reg_rdata_out = s.rdata;
  assign orient_interrupt_source_out =
    s.orient_change_flag && orient_int_enable_in;

  // ******************************
  // checks
  // ******************************
  chk_read_clears_flag: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    rd_status && !set_evt |=> !s.orient_change_flag && 
      !orient_interrupt_source_out)
    else $error("status read did not clear change flag");

  chk_set_beats_clear: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    set_evt |=> s.orient_change_flag)
    else $error("detected change was lost");

  chk_change_flags: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !$stable({s.portrait_landscape_code, s.back_front_flag,
      s.z_tilt_lockout_flag}) |-> s.orient_change_flag)
    else $error("orientation changed without change flag");

  chk_hold_over_limit: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    over && !mode_change |=> $stable({s.portrait_landscape_code,
      s.back_front_flag,
      s.z_tilt_lockout_flag}) && $stable(s.dbc))
    else $error("orientation moved above 1.25g");

  chk_disabled_holds: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !s.orient_detect_enable |=> $stable(s.portrait_landscape_code)
      && !set_evt)
    else $error("orientation updated while disabled");

  chk_clear_mode: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    step && !over && !differ && !s.first_pending && s.debounce_mode
      && !mode_change |=> s.dbc == 8'h00)
    else $error("clear mode did not clear debounce counter");

  chk_decrement_mode: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    step && !over && !differ && !s.first_pending && !s.debounce_mode
      && !mode_change && s.dbc != 8'h00 |=> s.dbc == $past(s.dbc) - 8'h01)
    else $error("decrement mode did not step counter down");

  chk_wake_sleep_reset: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    mode_change |=> s.dbc == 8'h00)
    else $error("wake/sleep change kept debounce count");

  chk_debounce_latency: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    step && differ && !over && !s.first_pending && !mode_change
      && s.dbc < s.debounce_count |=> $stable(s.portrait_landscape_code)
      && $stable(s.back_front_flag) && $stable(s.z_tilt_lockout_flag))
    else $error("orientation changed before debounce count");

  chk_status_layout: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    reg_rd_in && reg_addr_in == ADDR_STATUS |=>
      reg_rdata_out == {$past(s.orient_change_flag),
      $past(s.z_tilt_lockout_flag), 3'h0,
      $past(s.portrait_landscape_code), $past(s.back_front_flag)})
    else $error("status register read back wrong");

  chk_zcomp_fixed: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    reg_rd_in && reg_addr_in == ADDR_ZCOMP |=> reg_rdata_out == 8'h44)
    else $error("compensation register not fixed");

  chk_reset_zero: assert property (
    @(posedge clk_in)
    sys_rst_in |=> s.orient_change_flag == 1'b0
      && s.portrait_landscape_code == 2'h0 && !s.back_front_flag
      && !s.z_tilt_lockout_flag && !s.orient_detect_enable
      && s.debounce_count == 8'h00 && reg_rdata_out == 8'h00)
    else $error("status not zero after reset");

  chk_irq_follows: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    $rose(orient_interrupt_source_out) |->
      $past(set_evt) || $rose(orient_int_enable_in))
    else $error("interrupt source rose without a detection");

endmodule // odr_orient

`default_nettype wire

/* design/odr_pkg.sv */
// odr_pkg: constants shared by the orientation detection block.
// assumes a 25 MHz system clock and 10-bit signed samples on 2g range.
`default_nettype none

package odr_pkg;

  // ******************************
  // register map
  // ******************************
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CONFIG = 8'h11;
  localparam logic [7:0] ADDR_COUNT  = 8'h12;
  localparam logic [7:0] ADDR_ZCOMP  = 8'h13;

  localparam int ST_FLAG_BIT  = 7;
  localparam int ST_LO_BIT    = 6;
  localparam int ST_CODE_LSB  = 1;
  localparam int ST_BF_BIT    = 0;
  localparam int CFG_MODE_BIT = 7;
  localparam int CFG_EN_BIT   = 6;

  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] ZCOMP_VALUE = 8'h44;

  // ******************************
  // orientation codes and modes
  // ******************************
  localparam logic [1:0] CODE_PORTRAIT_UP   = 2'h0;
  localparam logic [1:0] CODE_PORTRAIT_DOWN = 2'h1;
  localparam logic [1:0] CODE_LAND_RIGHT    = 2'h2;
  localparam logic [1:0] CODE_LAND_LEFT     = 2'h3;

  typedef enum logic [1:0] {
    ODR_STANDBY, ODR_WAKE, ODR_SLEEP
  } odr_sysmode_e;

  typedef enum logic [1:0] {
    ODR_OS_NORMAL, ODR_OS_LOW_POWER_LOW_NOISE_MODE, ODR_OS_HIGH_RESOLUTION_MODE, ODR_OS_LOWPOWER
  } odr_osmode_e;

  // ******************************
  // timing and thresholds
  // ******************************
  localparam int CLK_HZ           = 25_000_000;
  localparam int STEP_BASE_NS     = 1_250_000;
  localparam int STEP_BASE_CYCLES = STEP_BASE_NS / (1_000_000_000 / CLK_HZ);
  localparam int ACCEL_W          = 10;
  localparam int ONE_G_COUNTS     = 256;
  localparam int HOLD_LIMIT       = ONE_G_COUNTS * 5 / 4;
  localparam int BF_Z_LIMIT       = 66;

endpackage

`default_nettype wire

/* design/odr_classify.sv */
// odr_classify: raw orientation candidate from one acceleration sample.
// assumes samples are held stable by the front end between updates.
`default_nettype none

module odr_classify
  import odr_pkg::*;
(
  // sample
  input  wire logic signed [ACCEL_W-1:0] ax_in,
  input  wire logic signed [ACCEL_W-1:0] ay_in,
  input  wire logic signed [ACCEL_W-1:0] az_in,
  // candidate
  output logic        [1:0]           code_out,
  output logic                        bf_out,
  output logic                        lo_out,
  output logic                        over_out
);

  logic [ACCEL_W-1:0] mx, my, mz;
  logic [2*ACCEL_W+2:0] tilt, flat;

  function automatic logic [ACCEL_W-1:0] mag(
      input logic signed [ACCEL_W-1:0] v);
    mag = v[ACCEL_W-1] ? ACCEL_W'(-v) : ACCEL_W'(v);
  endfunction

  always_comb begin
    mx = mag(ax_in);
    my = mag(ay_in);
    mz = mag(az_in);
    // lockout when tilt from flat is under 30 deg: 3*(x2+y2) < z2
    tilt = (2*ACCEL_W+3)'(3 * (mx * mx + my * my));
    flat = (2*ACCEL_W+3)'(mz * mz);
    lo_out = flat > tilt;
    bf_out = az_in < -(ACCEL_W)'(BF_Z_LIMIT);
    over_out = (mx > ACCEL_W'(HOLD_LIMIT)) || (my > ACCEL_W'(HOLD_LIMIT))
      || (mz > ACCEL_W'(HOLD_LIMIT));
    if (mx > my) begin
      code_out = ax_in[ACCEL_W-1] ? CODE_LAND_LEFT : CODE_LAND_RIGHT;
    end else begin
      code_out = ay_in[ACCEL_W-1] ? CODE_PORTRAIT_DOWN : CODE_PORTRAIT_UP;
    end
  end

endmodule // odr_classify

`default_nettype wire

/* verif/odr_host_model.sv */
// odr_host_model: register master standing in for the host processor.
// assumes one-cycle strobes and read data valid one cycle after the read.
`default_nettype none

module odr_host_model (
  // clock
  input  wire logic       clk_in,
  // register port
  output var  logic [7:0] reg_addr_out,
  output var  logic       reg_wr_out,
  output var  logic       reg_rd_out,
  output var  logic [7:0] reg_wdata_out,
  input  wire logic [7:0] reg_rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end

  // ******************************
  // single-byte transfers
  // ******************************
  // address and data are inverted once released so stale values never match
  task automatic put(input logic [7:0] a, input logic [7:0] d,
                     input logic w);
    @(posedge clk_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = w;
    reg_rd_out = !w;
    @(posedge clk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    put(a, d, 1'b1);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'b0);
    d = reg_rdata_in;
  endtask
endmodule // odr_host_model

`default_nettype wire

/* verif/orientation_detect_regs_tb_top.sv */
// orientation_detect_regs_tb_top: self-checking bench for odr_orient.
// assumes a shortened step of 4 clocks and output data rate code 0
// except in the slow data rate scenario near the end.
`default_nettype none

module orientation_detect_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import odr_pkg::*;

  localparam int STEP = 4;
  localparam int SETTLE = 10 * STEP;

  logic                      clk_in = 1'b0;
  logic                      sys_rst_in = 1'b1;
  logic [7:0]                addr;
  logic [7:0]                wdata;
  logic [7:0]                rdata;
  logic                      wr;
  logic                      rd;
  logic signed [ACCEL_W-1:0] ax = '0;
  logic signed [ACCEL_W-1:0] ay = '0;
  logic signed [ACCEL_W-1:0] az = '0;
  odr_sysmode_e              sys_mode = ODR_STANDBY;
  odr_osmode_e               os_mode = ODR_OS_NORMAL;
  logic [2:0]                odr_code = 3'h0;
  logic                      int_en = 1'b0;
  logic                      int_src;
  int                        bad_count = 0;
  int                        cmp_count = 0;
  integer                    seed = 35660;
  logic [7:0]                prev;
  logic [7:0]                exp;
  logic                      flag;
  int                        vx[6] = '{0, 0, 200, -200, 0, 10};
  int                        vy[6] = '{200, -200, 0, 0, 200, 10};
  int                        vz[6] = '{50, 50, 50, 50, -200, 250};

  always #20 clk_in = ~clk_in;

  odr_host_model i_host (
    .clk_in        (clk_in),
    .reg_addr_out  (addr),
    .reg_wr_out    (wr),
    .reg_rd_out    (rd),
    .reg_wdata_out (wdata),
    .reg_rdata_in  (rdata)
  );

  odr_orient #(.STEP_CYCLES(STEP)) i_dut (
    .clk_in                      (clk_in),
    .sys_rst_in                  (sys_rst_in),
    .reg_addr_in                 (addr),
    .reg_wr_in                   (wr),
    .reg_rd_in                   (rd),
    .reg_wdata_in                (wdata),
    .reg_rdata_out               (rdata),
    .ax_in                       (ax),
    .ay_in                       (ay),
    .az_in                       (az),
    .sys_mode_in                 (sys_mode),
    .os_mode_in                  (os_mode),
    .odr_code_in                 (odr_code),
    .orient_int_enable_in        (int_en),
    .orient_interrupt_source_out (int_src)
  );

  // ******************************
  // checking helpers
  // ******************************
  task automatic chk8(input string what, input logic [7:0] e,
                      input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk1(input string what, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input string what);
    logic [7:0] d;
    i_host.rd_reg(a, d);
    chk8(what, e, d);
  endtask

  // status byte without the change flag for one sample
  function automatic logic [7:0] orient(input int x, input int y,
                                        input int z);
    logic [7:0] s;
    s = 8'h00;
    if ((x < 0 ? -x : x) > (y < 0 ? -y : y))
      s[2:1] = (x < 0) ? CODE_LAND_LEFT : CODE_LAND_RIGHT;
    else
      s[2:1] = (y < 0) ? CODE_PORTRAIT_DOWN : CODE_PORTRAIT_UP;
    s[0] = (z < -BF_Z_LIMIT);
    s[6] = (z * z > 3 * (x * x + y * y));
    return s;
  endfunction

  task automatic acc(input int x, input int y, input int z);
    @(posedge clk_in);
    #1;
    ax = x[ACCEL_W-1:0];
    ay = y[ACCEL_W-1:0];
    az = z[ACCEL_W-1:0];
  endtask

  task automatic mode(input odr_sysmode_e m);
    @(posedge clk_in);
    #1;
    sys_mode = m;
  endtask

  // returns just after the edge so that outputs are settled when looked at
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ******************************
  // main sequence
  // ******************************
  initial begin
    cyc(20);
    sys_rst_in = 1'b0;
    chk8("rdata after reset", 8'h00, rdata);
    rd_chk(ADDR_STATUS, 8'h00, "status reset");
    rd_chk(ADDR_CONFIG, 8'h00, "config reset");
    rd_chk(ADDR_COUNT, 8'h00, "count reset");
    rd_chk(ADDR_ZCOMP, 8'h44, "zcomp");
    rd_chk(8'h20, 8'h00, "unmapped");
    i_host.wr_reg(ADDR_ZCOMP, 8'h00);
    i_host.wr_reg(ADDR_STATUS, 8'hff);
    rd_chk(ADDR_ZCOMP, 8'h44, "zcomp after write");
    rd_chk(ADDR_STATUS, 8'h00, "status after write");
    i_host.wr_reg(ADDR_CONFIG, 8'hff);
    rd_chk(ADDR_CONFIG, 8'hc0, "config bits");
    i_host.wr_reg(ADDR_COUNT, 8'ha5);
    rd_chk(ADDR_COUNT, 8'ha5, "count write");
    i_host.wr_reg(ADDR_CONFIG, 8'h00);
    i_host.wr_reg(ADDR_COUNT, 8'h00);
    // detection stays quiet while disabled
    acc(-200, 10, 100);
    mode(ODR_WAKE);
    cyc(SETTLE);
    rd_chk(ADDR_STATUS, 8'h00, "status disabled");
    int_en = 1'b1;
    i_host.wr_reg(ADDR_CONFIG, 8'h40);
    cyc(SETTLE);
    chk1("interrupt set", 1'b1, int_src);
    rd_chk(ADDR_STATUS, 8'h80 | orient(-200, 10, 100), "first");
    chk1("interrupt cleared", 1'b0, int_src);
    rd_chk(ADDR_STATUS, orient(-200, 10, 100), "flag cleared");
    // every code, back facing and lockout
    for (int i = 0; i < 6; i++) begin
      acc(vx[i], vy[i], vz[i]);
      cyc(SETTLE);
      exp = 8'h80 | orient(vx[i], vy[i], vz[i]);
      rd_chk(ADDR_STATUS, exp, "code table");
    end
    // fields keep moving while the flag is still set
    acc(0, 200, 50);
    cyc(SETTLE);
    acc(200, 0, 50);
    cyc(SETTLE);
    rd_chk(ADDR_STATUS, 8'h80 | orient(200, 0, 50), "no freeze");
    prev = orient(200, 0, 50);
    // random samples with the flag predicted from the last report
    for (int i = 0; i < 12; i++) begin
      acc($random(seed) % 300, $random(seed) % 300, $random(seed) % 300);
      int_en = $random(seed);
      os_mode = odr_osmode_e'($random(seed) & 3);
      cyc(SETTLE);
      exp = orient(ax, ay, az);
      flag = (exp !== prev);
      chk1("interrupt source", flag & int_en, int_src);
      rd_chk(ADDR_STATUS, {flag, exp[6:0]}, "random status");
      prev = exp;
    end
    // hold above the magnitude limit, update right at it
    acc(0, 200, 50);
    cyc(SETTLE);
    rd_chk(ADDR_STATUS, {1'b0 | (prev != 8'h00), 7'h00}, "setup up");
    acc(330, 0, 0);
    cyc(SETTLE);
    rd_chk(ADDR_STATUS, 8'h00, "held over limit");
    acc(320, 0, 0);
    cyc(SETTLE);
    rd_chk(ADDR_STATUS, 8'h80 | orient(320, 0, 0), "at limit");
    // debounce count delays the change
    i_host.wr_reg(ADDR_COUNT, 8'h05);
    acc(0, 200, 50);
    cyc(2 * STEP);
    rd_chk(ADDR_STATUS, orient(320, 0, 0), "debounce early");
    cyc(SETTLE);
    rd_chk(ADDR_STATUS, 8'h80, "debounce done");
    // wake and sleep swaps restart the debounce
    acc(-200, 0, 50);
    cyc(3 * STEP);
    mode(ODR_SLEEP);
    cyc(3 * STEP);
    mode(ODR_WAKE);
    cyc(3 * STEP);
    rd_chk(ADDR_STATUS, 8'h00, "mode swap restart");
    cyc(SETTLE);
    rd_chk(ADDR_STATUS, 8'h80 | orient(-200, 0, 50), "after swap");
    // a slower data rate stretches each debounce step to 4 base steps
    os_mode = ODR_OS_NORMAL;
    odr_code = 3'h2;
    i_host.wr_reg(ADDR_COUNT, 8'h02);
    acc(0, 200, 50);
    cyc(7 * STEP);
    rd_chk(ADDR_STATUS, orient(-200, 0, 50), "slow step early");
    cyc(SETTLE);
    rd_chk(ADDR_STATUS, 8'h80, "slow step done");
    report_and_stop();
  end

  // the whole run needs about 1340 clocks
  initial begin
    cyc(20000);
    bad_count++;
    report_and_stop();
  end
endmodule // orientation_detect_regs_tb_top

`default_nettype wire
